/* logic/bfr_pkg.sv */
// constants, carriers and state records for the burst flash read block
// assumes one system clock and one host burst clock, each with its own logic
package bfr_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int UPPER_W = ADDR_W - DATA_W;
	localparam int BANK_W = 4;
	localparam int SECTOR_W = 8;
	localparam int BANK_LSB = ADDR_W - BANK_W;
	localparam int SECTOR_LSB = ADDR_W - SECTOR_W;
	localparam int CFG_W = 16;
	localparam int CFG_MODE_BIT = 15;
	localparam int CFG_RATE_BIT = 14;
	localparam int CFG_LAT_LSB = 11;
	localparam int BOUND_BITS = 7;
	localparam int PAGE_BITS = 2;
	localparam logic CFG_MODE_RST = 1'h1;
	localparam logic CFG_RATE_RST = 1'h0;
	localparam logic [2:0] CFG_LAT_RST = 3'h5;
	localparam logic [2:0] LAT_MIN = 3'h3;
	localparam logic [2:0] LAT_MAX = 3'h5;
	localparam logic [3:0] LAT_EDGE_ADD = 4'h2;
	localparam logic [3:0] BASE_WS_TOP = 4'h2;
	localparam logic [3:0] BASE_WS_HI = 4'h1;
	localparam real CLK_NS = 10.0;
	localparam real ACC_NS = 80.0;
	localparam real PACC_NS = 20.0;
	localparam real OE_NS = 13.5;

	// longest times: round down, never below one cycle
	function automatic logic [3:0] bfr_cycles(input real t_ns);
		int n;
		n = int'(t_ns * 10.0) / int'(CLK_NS * 10.0);
		return (n < 1) ? 4'h1 : n[3:0];
	endfunction : bfr_cycles

	localparam logic [3:0] ACC_CYC = bfr_cycles(ACC_NS);
	localparam logic [3:0] PACC_CYC = bfr_cycles(PACC_NS);
	localparam logic [3:0] OE_CYC = bfr_cycles(OE_NS);

	typedef struct packed {
		logic cs_n;
		logic avd_n;
		logic oe_n;
		logic we_n;
		logic [UPPER_W-1:0] upper_addr;
		logic [DATA_W-1:0] bus_in;
	} bfr_pin_in_s;

	typedef struct packed {
		logic [DATA_W-1:0] bus_out;
		logic bus_oe;
		logic ready;
	} bfr_pin_out_s;

	typedef struct packed {
		logic busy_valid;
		logic [BANK_W-1:0] busy_bank;
		logic esus_valid;
		logic [SECTOR_W-1:0] esus_sector;
		logic psus_valid;
		logic [SECTOR_W-1:0] psus_sector;
		logic [DATA_W-1:0] status_word;
	} bfr_bank_s;

	typedef enum logic [2:0] {
		A_IDLE = 3'h1,
		A_ACCESS = 3'h2,
		A_VALID = 3'h4
	} bfr_astate_e;

	typedef enum logic [3:0] {
		B_IDLE = 4'h1,
		B_WAIT = 4'h2,
		B_DATA = 4'h4,
		B_GAP = 4'h8
	} bfr_bstate_e;

	typedef struct packed {
		bfr_astate_e state;
		logic [3:0] cnt;
		logic [3:0] oe_cnt;
		logic [ADDR_W-1:0] addr;
		logic page_open;
		logic [DATA_W-1:0] data;
		logic data_ok;
		logic drive;
		logic avd_q_n;
		logic cfg_async;
		logic cfg_rate;
		logic [2:0] cfg_lat;
	} bfr_async_s;

	typedef struct packed {
		bfr_bstate_e state;
		logic [3:0] cnt;
		logic [ADDR_W-1:0] fetch;
		logic [1:0] start_off;
		logic first_grp;
		logic [DATA_W-1:0] dq;
		logic ready;
		logic oe;
	} bfr_burst_s;

	localparam bfr_async_s ASYNC_RST = '{state: A_IDLE, cnt: 4'h0, oe_cnt: 4'h0,
		addr: 24'h0, page_open: 1'h0, data: 16'h0, data_ok: 1'h0, drive: 1'h0,
		avd_q_n: 1'h1, cfg_async: CFG_MODE_RST, cfg_rate: CFG_RATE_RST,
		cfg_lat: CFG_LAT_RST};
	localparam bfr_burst_s BURST_RST = '{state: B_IDLE, cnt: 4'h0, fetch: 24'h0,
		start_off: 2'h0, first_grp: 1'h0, dq: 16'h0, ready: 1'h1, oe: 1'h0};
endpackage : bfr_pkg

/* logic/bfr_sync2.sv */
// two-stage synchroniser for levels entering a clock domain
// assumes the source bits are quasi-static or individually meaningful
`timescale 1ns/10ps
module bfr_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// no reset: also used to release the reset into the link domain
	always_ff @(posedge clk) begin
		meta_reg <= d;
		q <= meta_reg;
	end
endmodule : bfr_sync2

/* logic/bfr_flash_read.sv */
// read side of a multiplexed-bus burst flash: async, page and burst reads
// assumes array reads answer combinationally within the same clock cycle
//
// Function
// (RL1) after reset, reads are asynchronous and need no command first
// (RL2) host keeps address valid, strobe and chip select low, write enable high
// (RL3) address is captured on the rising edge of the address-valid strobe
// (RL4) host lowers output enable after strobe rise; data follows after OE time
// (RL5) upper bits pick a four-word page, two low bits the word in it
// (RL6) same-page words use the short access; chip select toggle forces full access
// (RL7) strobe toggle starts full access; strobe low needs stable address
// (RL8) a bank serves array data again once its algorithm completes
// (RL9) erase-suspended sectors return status, other sectors array data
// (RL10) program suspend allows reads from sectors not program-suspended
// (RL11) host toggles chip select or strobe for each status poll
// (RL12) burst reads only after config write clears the mode bit
// (RL13) first burst word after programmed latency from capture edge
// (RL14) each later word per clock edge, address counter advancing likewise
// (RL15) unaligned start adds one to three waits after the first group
// (RL16) high clock rate adds one wait per 128-word boundary crossing
// (RL17) top rate with seven waits adds two before the fifth word
// (RL18) latency selectable as five, six or seven waits
// (RL19) higher clock rates use more waits after the initial word
// (RL20) ready output shows each valid burst word, with or without waits
// (RL21) mode bit: zero selects burst, one async, one at reset
// (RL22) continuous burst wraps and runs until chip select, reset or new address
// (RL23) host samples data only on edges where ready is high
`timescale 1ns/10ps
module bfr_flash_read (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic burst_clk,
	input wire bfr_pkg::bfr_pin_in_s pin_in,
	output bfr_pkg::bfr_pin_out_s pin_out,
	input wire logic cfg_wr,
	input wire logic [bfr_pkg::CFG_W-1:0] cfg_data,
	input wire bfr_pkg::bfr_bank_s bank_state,
	output logic [bfr_pkg::ADDR_W-1:0] array_addr,
	input wire logic [bfr_pkg::DATA_W-1:0] array_data,
	output logic [bfr_pkg::ADDR_W-1:0] burst_word_addr,
	input wire logic [bfr_pkg::DATA_W-1:0] burst_word_data
);
	import bfr_pkg::*;

	bfr_async_s a_reg;
	bfr_async_s a_next;
	bfr_burst_s l_reg;
	bfr_burst_s l_next;
	bfr_pin_in_s sp;
	logic lrst_b;
	logic [4:0] lcfg;
	logic [ADDR_W-1:0] cur_addr;
	logic a_rise;
	logic a_ok;
	logic a_full;
	logic a_page;
	logic a_hit;
	logic [2:0] llat;
	logic lsync;
	logic lrate;
	logic [3:0] l_gap;
	logic l_quiet;
	logic l_cap;
	logic [3:0] l_edge;

	function automatic logic status_hit(input logic [ADDR_W-1:0] a, input bfr_bank_s b);
		logic bank_busy;
		logic esus;
		logic psus;
		bank_busy = b.busy_valid && (a[ADDR_W-1:BANK_LSB] == b.busy_bank);
		esus = b.esus_valid && (a[ADDR_W-1:SECTOR_LSB] == b.esus_sector);
		psus = b.psus_valid && (a[ADDR_W-1:SECTOR_LSB] == b.psus_sector);
		return bank_busy || esus || psus;
	endfunction : status_hit

	// extra waits before the word now at the fetch pointer
	function automatic logic [3:0] burst_gap(input logic [ADDR_W-1:0] f, input logic first,
		input logic [1:0] off, input logic rate, input logic [2:0] lat);
		logic [3:0] g;
		g = 4'h0;
		if (first && f[PAGE_BITS-1:0] == 2'h0) begin
			g = {2'h0, off};
			if (rate) begin
				g = g + ((lat == LAT_MAX) ? BASE_WS_TOP : BASE_WS_HI);
			end
		end
		if (rate && f[BOUND_BITS-1:0] == 7'h0) begin
			g = g + 4'h1;
		end
		return g;
	endfunction : burst_gap

	// pins into the system clock domain
	bfr_sync2 #(.W($bits(bfr_pin_in_s))) u_pin_sync (
		.clk(clk),
		.d(pin_in),
		.q(sp)
	);

	bfr_sync2 #(.W(1)) u_rst_sync (
		.clk(burst_clk),
		.d(rst_b),
		.q(lrst_b)
	);

	// config is quasi-static; only changed while no burst runs
	bfr_sync2 #(.W(5)) u_cfg_sync (
		.clk(burst_clk),
		.d({a_reg.cfg_async, a_reg.cfg_rate, a_reg.cfg_lat}),
		.q(lcfg)
	);

	assign cur_addr = {sp.upper_addr, sp.bus_in};
	assign a_rise = !a_reg.avd_q_n && sp.avd_n;
	assign a_ok = !sp.cs_n && sp.we_n && a_reg.cfg_async;
	assign a_hit = status_hit(a_reg.addr, bank_state);

	always_comb begin
		a_full = 1'b0;
		a_page = 1'b0;
		if (a_ok) begin
			if (a_rise) begin
				a_full = 1'b1; // RL3 RL7
			end else if (!sp.avd_n && cur_addr != a_reg.addr) begin
				if (a_reg.page_open && cur_addr[ADDR_W-1:PAGE_BITS] ==
					a_reg.addr[ADDR_W-1:PAGE_BITS]) begin
					a_page = 1'b1; // RL5 RL6
				end else begin
					a_full = 1'b1; // RL7
				end
			end
		end
	end

	always_comb begin
		a_next = a_reg;
		a_next.avd_q_n = sp.avd_n;
		if (cfg_wr) begin
			a_next.cfg_async = cfg_data[CFG_MODE_BIT]; // RL12 RL21
			a_next.cfg_rate = cfg_data[CFG_RATE_BIT]; // RL19
			a_next.cfg_lat = cfg_data[CFG_LAT_LSB+2:CFG_LAT_LSB];
		end
		if (!a_ok) begin
			// write cycles and deselect end any open read
			a_next.state = A_IDLE; // RL2 RL6
			a_next.page_open = 1'b0;
			a_next.data_ok = 1'b0;
			a_next.oe_cnt = 4'h0;
		end else begin
			if (a_full) begin
				a_next.addr = cur_addr;
				a_next.cnt = ACC_CYC; // RL1 RL7
				a_next.state = A_ACCESS;
				a_next.page_open = 1'b0;
				a_next.data_ok = 1'b0;
			end else if (a_page) begin
				a_next.addr = cur_addr;
				a_next.cnt = PACC_CYC; // RL6
				a_next.state = A_ACCESS;
				a_next.data_ok = 1'b0;
			end else if (a_reg.state == A_ACCESS) begin
				if (a_reg.cnt == 4'h1) begin
					// status is fetched once per access; polling needs a new access
					a_next.data = a_hit ? bank_state.status_word : array_data; // RL8 RL9 RL10 RL11
					a_next.data_ok = 1'b1;
					a_next.page_open = 1'b1;
					a_next.state = A_VALID;
				end else begin
					a_next.cnt = a_reg.cnt - 4'h1;
				end
			end
			if (sp.oe_n) begin
				a_next.oe_cnt = 4'h0;
			end else if (a_reg.oe_cnt != OE_CYC) begin
				a_next.oe_cnt = a_reg.oe_cnt + 4'h1; // RL4
			end
		end
		a_next.drive = a_next.data_ok && a_next.oe_cnt == OE_CYC; // RL4
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			a_reg <= ASYNC_RST; // RL1 RL21
		end else begin
			a_reg <= a_next;
		end
	end

	assign lsync = !lcfg[4];
	assign lrate = lcfg[3];

	always_comb begin
		llat = lcfg[2:0];
		if (llat < LAT_MIN) begin
			llat = LAT_MIN; // RL18
		end else if (llat > LAT_MAX) begin
			llat = LAT_MAX; // RL18
		end
	end

	assign l_cap = lsync && !pin_in.cs_n && !pin_in.avd_n;
	assign l_quiet = lsync && !pin_in.cs_n && pin_in.avd_n;
	assign l_gap = burst_gap(l_reg.fetch, l_reg.first_grp, l_reg.start_off, lrate, llat);

	// pins are synchronous to the burst clock, so they are sampled directly
	always_comb begin
		l_next = l_reg;
		l_next.oe = lsync && !pin_in.cs_n && !pin_in.oe_n;
		if (!lsync || pin_in.cs_n) begin
			l_next.state = B_IDLE; // RL12 RL22
			l_next.ready = 1'b1;
			l_next.first_grp = 1'b0;
		end else if (!pin_in.avd_n) begin
			l_next.fetch = {pin_in.upper_addr, pin_in.bus_in}; // RL22
			l_next.start_off = pin_in.bus_in[PAGE_BITS-1:0];
			l_next.cnt = {1'b0, llat} + LAT_EDGE_ADD; // RL13
			l_next.state = B_WAIT;
			l_next.ready = 1'b0;
			l_next.first_grp = 1'b1;
		end else begin
			unique case (l_reg.state)
				B_IDLE: begin
					l_next.ready = 1'b1;
				end
				B_WAIT, B_GAP: begin
					if (l_reg.cnt == 4'h1) begin
						l_next.dq = burst_word_data; // RL13 RL20
						l_next.fetch = l_reg.fetch + 24'h1;
						l_next.ready = 1'b1;
						l_next.state = B_DATA;
					end else begin
						l_next.cnt = l_reg.cnt - 4'h1;
						l_next.ready = 1'b0; // RL20
					end
				end
				B_DATA: begin
					if (l_reg.fetch[PAGE_BITS-1:0] == 2'h0) begin
						l_next.first_grp = 1'b0;
					end
					if (l_gap != 4'h0) begin
						l_next.cnt = l_gap; // RL15 RL16 RL17 RL19
						l_next.ready = 1'b0; // RL20
						l_next.state = B_GAP;
					end else begin
						// counter wraps at the top address on its own
						l_next.dq = burst_word_data; // RL14 RL22
						l_next.fetch = l_reg.fetch + 24'h1; // RL14
						l_next.ready = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge burst_clk) begin
		if (!lrst_b) begin
			l_reg <= BURST_RST;
		end else begin
			l_reg <= l_next;
		end
	end

	// pin owner follows the mode bit, which only moves between bursts
	always_comb begin
		if (!a_reg.cfg_async) begin
			pin_out.bus_out = l_reg.dq;
			pin_out.bus_oe = l_reg.oe;
			pin_out.ready = l_reg.ready; // RL20 RL23
		end else begin
			pin_out.bus_out = a_reg.data;
			pin_out.bus_oe = a_reg.drive;
			pin_out.ready = 1'b1;
		end
	end

	assign array_addr = a_reg.addr;
	assign burst_word_addr = l_reg.fetch;

	// edges since the last capture, for latency checks
	always_ff @(posedge burst_clk) begin
		if (!lrst_b || l_cap) begin
			l_edge <= 4'h0;
		end else if (l_edge != 4'hf) begin
			l_edge <= l_edge + 4'h1;
		end
	end

	sequence s_full_run;
		a_full ##1 (a_ok && !a_full && !a_page)[*8];
	endsequence

	sequence s_page_run;
		a_page ##1 (a_ok && !a_full && !a_page)[*2];
	endsequence

	property p_full_access;
		@(posedge clk) disable iff (!rst_b)
		s_full_run |=> a_reg.data_ok && $past(!a_reg.data_ok);
	endproperty
	a_full_access: assert property (p_full_access) else $error("full access not 8 cycles"); // RL1

	property p_page_access;
		@(posedge clk) disable iff (!rst_b)
		s_page_run |=> a_reg.data_ok && $past(!a_reg.data_ok);
	endproperty
	a_page_access: assert property (p_page_access) else $error("page access not 2 cycles"); // RL6

	property p_deselect;
		@(posedge clk) disable iff (!rst_b)
		sp.cs_n |=> !a_reg.page_open && !a_reg.drive;
	endproperty
	a_deselect: assert property (p_deselect) else $error("page kept across deselect"); // RL6

	property p_capture;
		@(posedge clk) disable iff (!rst_b)
		a_ok && a_rise |=> a_reg.addr == $past(cur_addr) && a_reg.state == A_ACCESS;
	endproperty
	a_capture: assert property (p_capture) else $error("address not captured"); // RL3

	property p_oe_drive;
		@(posedge clk) disable iff (!rst_b)
		a_reg.drive |-> a_reg.data_ok && $past(!sp.oe_n);
	endproperty
	a_oe_drive: assert property (p_oe_drive) else $error("bus driven without oe"); // RL4

	property p_status;
		@(posedge clk) disable iff (!rst_b)
		a_ok && !a_full && !a_page && a_reg.state == A_ACCESS && a_reg.cnt == 4'h1
		|=> a_reg.data == ($past(a_hit) ? $past(bank_state.status_word) : $past(array_data));
	endproperty
	a_status: assert property (p_status) else $error("wrong status or array word"); // RL9

	property p_mode;
		@(posedge clk) disable iff (!rst_b)
		$fell(a_reg.cfg_async) |-> $past(cfg_wr) && $past(!cfg_data[CFG_MODE_BIT]);
	endproperty
	a_mode: assert property (p_mode) else $error("burst mode without config write"); // RL12

	property p_latency;
		@(posedge burst_clk) disable iff (!lrst_b)
		l_reg.state == B_DATA && $past(l_reg.state == B_WAIT)
		|-> l_edge == {1'b0, llat} + LAT_EDGE_ADD && l_reg.ready;
	endproperty
	a_latency: assert property (p_latency) else $error("initial latency wrong"); // RL13

	property p_step;
		@(posedge burst_clk) disable iff (!lrst_b)
		l_reg.state == B_DATA && l_gap == 4'h0 && l_quiet
		|=> l_reg.ready && l_reg.fetch == $past(l_reg.fetch) + 24'h1;
	endproperty
	a_step: assert property (p_step) else $error("burst did not advance"); // RL14

	sequence s_gap3;
		(l_reg.state == B_DATA && l_gap == 4'h3 && l_quiet) ##1 l_quiet[*3];
	endsequence

	property p_gap3;
		@(posedge burst_clk) disable iff (!lrst_b)
		s_gap3 |=> l_reg.ready && $past(!l_reg.ready, 1) && $past(!l_reg.ready, 3);
	endproperty
	a_gap3: assert property (p_gap3) else $error("three-wait gap wrong"); // RL15

	property p_boundary;
		@(posedge burst_clk) disable iff (!lrst_b)
		l_reg.state == B_DATA && !l_reg.first_grp && lrate && l_reg.fetch[6:0] == 7'h0
		|-> l_gap == 4'h1;
	endproperty
	a_boundary: assert property (p_boundary) else $error("boundary wait missing"); // RL16

	property p_top_rate;
		@(posedge burst_clk) disable iff (!lrst_b)
		l_reg.state == B_DATA && l_reg.first_grp && lrate && llat == LAT_MAX
		&& l_reg.fetch[1:0] == 2'h0 && l_reg.fetch[6:0] != 7'h0
		|-> l_gap == {2'h0, l_reg.start_off} + 4'h2;
	endproperty
	a_top_rate: assert property (p_top_rate) else $error("top-rate waits wrong"); // RL17

	property p_cs_end;
		@(posedge burst_clk) disable iff (!lrst_b)
		pin_in.cs_n |=> l_reg.state == B_IDLE && !l_reg.oe;
	endproperty
	a_cs_end: assert property (p_cs_end) else $error("burst not ended by deselect"); // RL22
endmodule : bfr_flash_read

/* dv/bfr_host_model.sv */
// host controller model driving the flash read pins
// assumes the bench calls its tasks; the released bus shows inverted data
`timescale 1ns/10ps
module bfr_host_model (
	input wire logic clk,
	input wire logic burst_clk,
	output bfr_pkg::bfr_pin_in_s pin_in
);
	import bfr_pkg::*;

	initial begin
		pin_in = '{cs_n: 1'h1, avd_n: 1'h1, oe_n: 1'h1, we_n: 1'h1, upper_addr: 8'h0,
			bus_in: 16'h0};
	end

	// write enable never lowered: this host only reads
	task automatic a_start(input logic [ADDR_W-1:0] a);
		@(negedge clk);
		pin_in.cs_n = 1'h0;
		pin_in.avd_n = 1'h0;
		{pin_in.upper_addr, pin_in.bus_in} = a;
		@(negedge clk);
		pin_in.avd_n = 1'h1;
		@(negedge clk);
		pin_in.bus_in = ~pin_in.bus_in;
		pin_in.oe_n = 1'h0;
	endtask : a_start

	// strobe held low, address stable until the next word
	task automatic a_page(input logic [ADDR_W-1:0] a);
		@(negedge clk);
		pin_in.avd_n = 1'h0;
		{pin_in.upper_addr, pin_in.bus_in} = a;
	endtask : a_page

	// chip select toggled between polls so each is a fresh access
	task automatic a_end();
		@(negedge clk);
		pin_in.cs_n = 1'h1;
		pin_in.oe_n = 1'h1;
		pin_in.avd_n = 1'h1;
		repeat (4) @(negedge clk);
	endtask : a_end

	task automatic b_start(input logic [ADDR_W-1:0] a);
		@(negedge burst_clk);
		pin_in.cs_n = 1'h0;
		pin_in.avd_n = 1'h0;
		{pin_in.upper_addr, pin_in.bus_in} = a;
		@(negedge burst_clk);
		pin_in.avd_n = 1'h1;
		pin_in.oe_n = 1'h0;
		pin_in.bus_in = ~pin_in.bus_in;
	endtask : b_start

	task automatic b_stop();
		@(negedge burst_clk);
		pin_in.cs_n = 1'h1;
		pin_in.oe_n = 1'h1;
		repeat (3) @(negedge burst_clk);
	endtask : b_stop
endmodule : bfr_host_model

/* dv/tb_top.sv */
// self-checking bench for the burst flash read block
// assumes array words are the address low half xor a fixed mask
`timescale 1ns/10ps
`define CHK(nm, got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb_top;
	import bfr_pkg::*;
	logic clk;
	logic burst_clk;
	logic rst_b;
	logic cfg_wr;
	logic [CFG_W-1:0] cfg_data;
	bfr_bank_s bank;
	bfr_pin_in_s pin_in;
	bfr_pin_out_s pin_out;
	logic [ADDR_W-1:0] array_addr;
	logic [ADDR_W-1:0] burst_word_addr;
	int miscompares = 0;
	int samples_checked = 0;
	int ticks = 0;
	int c_full;
	int c_pg;

	bfr_host_model hst (.clk(clk), .burst_clk(burst_clk), .pin_in(pin_in));
	bfr_flash_read dut (.clk(clk), .rst_b(rst_b), .burst_clk(burst_clk), .pin_in(pin_in),
		.pin_out(pin_out), .cfg_wr(cfg_wr), .cfg_data(cfg_data), .bank_state(bank),
		.array_addr(array_addr), .array_data(array_addr[15:0] ^ 16'h3c3c),
		.burst_word_addr(burst_word_addr),
		.burst_word_data(burst_word_addr[15:0] ^ 16'h5a5a));

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// link clock offset by 7 ns, yet its edges still meet clk edges every 120 ns
	initial begin
		burst_clk = 1'h0;
		#7;
		forever #24 burst_clk = ~burst_clk;
	end
	always @(posedge clk) begin
		ticks++;
		if (ticks == 20000) begin
			miscompares++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	// held long enough for the link-side reset flops as well
	task automatic do_reset();
		@(negedge clk);
		rst_b = 1'h0;
		repeat (16) @(negedge clk);
		rst_b = 1'h1;
		@(negedge clk);
		`CHK("ready", pin_out.ready, 1'h1)
		`CHK("oe", pin_out.bus_oe, 1'h0)
	endtask : do_reset

	task automatic wt(input logic [DATA_W-1:0] exp, output int cyc);
		cyc = 0;
		while (cyc < 40 && !(pin_out.bus_oe === 1'h1 && pin_out.bus_out === exp)) begin
			@(negedge clk);
			cyc++;
		end
		`CHK("oe_on", pin_out.bus_oe, 1'h1)
		`CHK("data", pin_out.bus_out, exp)
	endtask : wt

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, output int cyc);
		hst.a_start(a);
		wt(exp, cyc);
		`CHK("addr", array_addr, a)
	endtask : rd

	task automatic t_page();
		rd(24'h000210, 16'h3e2c, c_full);
		for (int w = 1; w < 4; w++) begin
			hst.a_page({22'h000084, w[1:0]});
			wt(16'h3e2c ^ w[15:0], c_pg);
			`CHK("page_fast", c_pg < c_full, 1'h1)
		end
		hst.a_end();
		rd(24'h000212, 16'h3e2e, c_pg);
		`CHK("reopen_full", c_pg > 6, 1'h1)
		hst.a_end();
	endtask : t_page

	task automatic t_status();
		logic [ADDR_W-1:0] ad [6] = '{24'h120004, 24'h130000, 24'h120000, 24'h130008,
			24'h150000, 24'h150000};
		logic [5:0] st = 6'b011001;
		int c;
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			bank = '{busy_valid: i == 4, busy_bank: 4'h1, esus_valid: i < 2, esus_sector: 8'h12,
				psus_valid: i inside {2, 3}, psus_sector: 8'h13, status_word: 16'h00a5};
			rd(ad[i], st[i] ? 16'h00a5 : ad[i][15:0] ^ 16'h3c3c, c);
			hst.a_end();
		end
	endtask : t_status

	task automatic t_async_only();
		hst.b_start(24'h000040);
		repeat (10) begin
			@(negedge burst_clk);
			`CHK("ready_async", pin_out.ready, 1'h1)
		end
		hst.b_stop();
	endtask : t_async_only

	// mode changes only while the burst side is idle
	task automatic cfg(input logic md, input logic rt, input logic [2:0] lat);
		@(negedge clk);
		cfg_wr = 1'h1;
		cfg_data = {md, rt, lat, 11'h0};
		@(negedge clk);
		cfg_wr = 1'h0;
		repeat (20) @(negedge clk);
	endtask : cfg

	task automatic t_burst(input logic [ADDR_W-1:0] a, input logic [2:0] lat, input logic rt);
		logic [ADDR_W-1:0] f;
		int gap;
		logic first;
		f = a;
		gap = 0;
		first = 1'h1;
		cfg(1'h0, rt, lat);
		hst.b_start(a);
		for (int i = 1; i < 26; i++) begin
			@(negedge burst_clk);
			if (i < lat + 2 || gap > 0) begin
				`CHK("ready_low", pin_out.ready, 1'h0)
				if (i >= lat + 2) gap--;
			end else begin
				`CHK("ready_high", pin_out.ready, 1'h1)
				`CHK("burst_oe", pin_out.bus_oe, 1'h1)
				`CHK("word", pin_out.bus_out, f[15:0] ^ 16'h5a5a)
				f++;
				if (f[1:0] == 2'h0 && first) begin
					gap = a[1:0] + (rt ? (lat == 3'h5 ? 2 : 1) : 0);
					first = 1'h0;
				end
				if (rt && f[6:0] == 7'h0) gap++;
			end
		end
		hst.b_stop();
		`CHK("released", pin_out.bus_oe, 1'h0)
	endtask : t_burst

	// a second strobe mid-burst restarts the full latency at the new address
	task automatic t_restart();
		cfg(1'h0, 1'h0, 3'h3);
		hst.b_start(24'h000500);
		repeat (6) @(negedge burst_clk);
		hst.b_start(24'h000600);
		repeat (4) @(negedge burst_clk);
		`CHK("restart_wait", pin_out.ready, 1'h0)
		@(negedge burst_clk);
		`CHK("restart_rdy", pin_out.ready, 1'h1)
		`CHK("restart_word", pin_out.bus_out, 16'h0600 ^ 16'h5a5a)
		hst.b_stop();
	endtask : t_restart

	initial begin
		rst_b = 1'h0;
		cfg_wr = 1'h0;
		cfg_data = '0;
		bank = '0;
		do_reset();
		t_page();
		t_status();
		t_async_only();
		t_burst(24'h000100, 3'h3, 1'h0);
		t_burst(24'h000201, 3'h4, 1'h0);
		t_burst(24'hfffffe, 3'h5, 1'h0);
		t_burst(24'h000303, 3'h5, 1'h0);
		t_burst(24'h00007c, 3'h5, 1'h1);
		t_burst(24'h0000f9, 3'h4, 1'h1);
		t_burst(24'h000042, 3'h5, 1'h1);
		t_restart();
		do_reset();
		rd(24'h000044, 16'h3c78, c_pg);
		hst.a_end();
		end_sim();
	end
endmodule : tb_top
